// *** hdl/abic_map.vh ***
// Constants for the converter control and bus interface block
`ifndef ABIC_MAP_VH
`define ABIC_MAP_VH
`define ABIC_RES_W 12
`define ABIC_FULL_BITS 5'd12
`define ABIC_SHORT_BITS 5'd8
`define ABIC_BIT_TIME_NS 500
`define ABIC_CLK_NS 10
`define ABIC_BIT_CYC ((`ABIC_BIT_TIME_NS + `ABIC_CLK_NS - 1) / `ABIC_CLK_NS)
`define ABIC_LOW_PAD 4'h0
`define ABIC_RESULT_RST 12'h000
`endif

// *** hdl/abic_sar.v ***
// Successive-approximation sequencer: trials bits from the MSB down
`timescale 1ns/1ns
`include "abic_map.vh"
module abic_sar #(
    parameter BIT_CYC = `ABIC_BIT_CYC
) (
    input wire clk_in, // System clock
    input wire srst_in, // Sync reset, active high
    input wire ce_in, // Clock enable
    input wire start_in, // Start strobe
    input wire short_in, // 1 = 8-bit conversion
    input wire cmp_in, // Comparator: input above trial level
    output reg [11:0] trial_out, // Trial code to the DAC
    output reg busy_out, // Conversion running
    output reg done_out, // One-cycle end strobe
    output reg [11:0] code_out // Final code
);
    reg [3:0] bit_r;
    reg [15:0] cnt_r;
    reg [4:0] left_r;
    always @(posedge clk_in) begin
        if (srst_in) begin
            trial_out <= 12'h000;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            code_out <= `ABIC_RESULT_RST;
            bit_r <= 4'hB;
            cnt_r <= 16'h0000;
            left_r <= 5'h00;
        end else if (ce_in) begin
            done_out <= 1'b0;
            if (!busy_out) begin
                if (start_in) begin
                    busy_out <= 1'b1;
                    trial_out <= 12'h800;
                    bit_r <= 4'hB;
                    cnt_r <= 16'h0000;
                    left_r <= short_in ? `ABIC_SHORT_BITS : `ABIC_FULL_BITS;
                end
            end else if (cnt_r != BIT_CYC[15:0] - 16'h0001) begin
                cnt_r <= cnt_r + 16'h0001;
            end else begin
                cnt_r <= 16'h0000;
                if (left_r == 5'h01) begin
                    // Untried bits of a short conversion stay zero
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                    code_out <= cmp_in ? trial_out : (trial_out & ~(12'h001 << bit_r));
                end else begin
                    trial_out <= (cmp_in ? trial_out : (trial_out & ~(12'h001 << bit_r)))
                        | (12'h001 << (bit_r - 4'h1));
                    bit_r <= bit_r - 4'h1;
                    left_r <= left_r - 5'h01;
                end
            end
        end
    end
endmodule // abic_sar

// *** hdl/abic_ctrl.v ***
// Converter bus interface: decode, start, busy and three-state result
`timescale 1ns/1ns
`include "abic_map.vh"
// Functional notes
// RQ1 - The block responds to its controls only while the active-low select is low.
// RQ2 - The byte/length select at start picks 12-bit when low and 8-bit when high.
// RQ3 - In byte mode a read gives the low byte when byte select is high, else the high byte.
// RQ4 - Read/convert high means data read and low means conversion start.
// RQ5 - The block is selected only while chip enable is also high.
// RQ6 - Busy stays high for the whole conversion and new starts are ignored meanwhile.
// RQ7 - The low byte holds the 4 LSBs above 4 zeros; word mode gives all 12 bits.
// RQ8 - With enable and select asserted, convert when read/convert is 0, read when 1.
// RQ9 - Data drivers stay off except during a selected read.
module abic_ctrl #(
    parameter RES_W = `ABIC_RES_W,
    parameter BIT_CYC = `ABIC_BIT_CYC
) (
    input wire clk_in, // 100 MHz clock
    input wire srst_in, // Sync reset, active high
    input wire clk_en_in, // Clock enable, freezes state when low
    input wire select_n_in, // Active-low select
    input wire chip_en_in, // Active-high chip enable
    input wire read_conv_in, // 1 = read, 0 = convert
    input wire byte_or_length_select_pin_in, // Byte address / short cycle
    input wire word_mode_in, // 1 = 12-bit word, 0 = two bytes
    input wire cmp_in, // Comparator result
    output wire [RES_W-1:0] trial_out, // Trial code to the DAC
    output wire conversion_busy_flag_out, // High during conversion
    output reg [RES_W-1:0] result_output_lines_out, // Data lines, output value
    output reg [RES_W-1:0] result_output_lines_oe_out // Data lines, drive enable
);
    // Command states: what the master presented at the last enabled edge
    localparam CMD_IDLE = 2'b00;
    localparam CMD_CONV = 2'b01;
    localparam CMD_READ = 2'b10;

    // Data-line formats
    localparam FMT_WORD = 2'b00;
    localparam FMT_HIGH = 2'b01;
    localparam FMT_LOW = 2'b10;

    wire selected;
    wire can_start;
    wire busy;
    wire done;
    wire [11:0] code;

    reg [1:0] cmd_r;
    reg [1:0] cmd_nxt;
    reg start_r;
    reg start_nxt;
    reg short_r;
    reg short_nxt;

    reg [RES_W-1:0] result_r;
    reg [1:0] fmt_nxt;
    reg [RES_W-1:0] data_nxt;
    reg rd_nxt;

    // Unselected controls are idle whatever read/convert shows
    function [1:0] cmd_decode;
        input sel;
        input rd;
        begin
            if (!sel)
                cmd_decode = CMD_IDLE; // [RQ1] [RQ5]
            else if (rd)
                cmd_decode = CMD_READ; // [RQ4] [RQ8]
            else
                cmd_decode = CMD_CONV; // [RQ4] [RQ8]
        end
    endfunction

    // Byte select picks the lane only when the bus is eight bits wide
    function [1:0] fmt_select;
        input word;
        input low;
        begin
            if (word)
                fmt_select = FMT_WORD; // [RQ7]
            else if (low)
                fmt_select = FMT_LOW; // [RQ3]
            else
                fmt_select = FMT_HIGH; // [RQ3]
        end
    endfunction

    // Byte lanes sit on the low eight lines, top four lines zero, so an 8-bit master needs no mask
    function [RES_W-1:0] fmt;
        input [RES_W-1:0] res;
        input [1:0] mode;
        begin
            case (mode)
                FMT_WORD: fmt = res; // [RQ7]
                FMT_HIGH: fmt = {4'h0, res[11:4]}; // [RQ3]
                FMT_LOW: fmt = {4'h0, res[3:0], `ABIC_LOW_PAD}; // [RQ3] [RQ7]
                default: fmt = {RES_W{1'b0}};
            endcase
        end
    endfunction

    // A convert request is taken only while the converter is free
    function start_allowed;
        input [1:0] now;
        input free;
        begin
            start_allowed = (now == CMD_CONV) && free; // [RQ6]
        end
    endfunction

    assign selected = chip_en_in & ~select_n_in; // [RQ1] [RQ5]
    // Status already covers the start cycle, so a second edge then is refused too
    assign can_start = ~(busy | start_r); // [RQ6]

    always @* begin
        cmd_nxt = cmd_decode(selected, read_conv_in);
        start_nxt = 1'b0;
        short_nxt = short_r;
        case (cmd_r)
            CMD_IDLE: begin
                if (start_allowed(cmd_nxt, can_start)) begin
                    start_nxt = 1'b1; // [RQ8]
                    short_nxt = byte_or_length_select_pin_in; // [RQ2]
                end
            end
            CMD_READ: begin
                // Read turning into convert is a fresh command edge as well
                if (start_allowed(cmd_nxt, can_start)) begin
                    start_nxt = 1'b1; // [RQ8]
                    short_nxt = byte_or_length_select_pin_in; // [RQ2]
                end
            end
            CMD_CONV: begin
                // A held convert never retriggers, even after busy falls
                start_nxt = 1'b0;
            end
            default: begin
                start_nxt = 1'b0;
            end
        endcase
    end

    // Read data is formatted ahead of its register so the lanes turn in one cycle
    always @* begin
        rd_nxt = (cmd_nxt == CMD_READ); // [RQ9]
        fmt_nxt = fmt_select(word_mode_in, byte_or_length_select_pin_in);
        data_nxt = {RES_W{1'b0}};
        if (rd_nxt) begin
            data_nxt = fmt(result_r, fmt_nxt); // [RQ3] [RQ7]
        end
    end

    // Previous command, used to find the first cycle of a convert request
    always @(posedge clk_in) begin
        if (srst_in) begin
            cmd_r <= CMD_IDLE;
        end else if (clk_en_in) begin
            cmd_r <= cmd_nxt;
        end
    end

    // Start is taken once per command edge; the sequencer sees it one cycle later
    always @(posedge clk_in) begin
        if (srst_in) begin
            start_r <= 1'b0;
        end else if (clk_en_in) begin
            start_r <= start_nxt; // [RQ6] [RQ8]
        end
    end

    // Length is latched with the start so later bus activity cannot change it
    always @(posedge clk_in) begin
        if (srst_in) begin
            short_r <= 1'b0;
        end else if (clk_en_in) begin
            short_r <= short_nxt; // [RQ2]
        end
    end

    // Result only moves at the end of a conversion; reads while busy see the old one
    always @(posedge clk_in) begin
        if (srst_in) begin
            result_r <= `ABIC_RESULT_RST;
        end else if (clk_en_in) begin
            if (done) begin
                result_r <= code;
            end
        end
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            result_output_lines_out <= {RES_W{1'b0}};
        end else if (clk_en_in) begin
            result_output_lines_out <= data_nxt; // [RQ3] [RQ7]
        end
    end

    // Drive enables follow the decoded read with one cycle of lag
    always @(posedge clk_in) begin
        if (srst_in) begin
            result_output_lines_oe_out <= {RES_W{1'b0}};
        end else if (clk_en_in) begin
            result_output_lines_oe_out <= {RES_W{rd_nxt}}; // [RQ9]
        end
    end

    abic_sar #(
        .BIT_CYC(BIT_CYC)
    ) u_abic_sar (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ce_in(clk_en_in),
        .start_in(start_r), // Ignored by the sequencer while busy [RQ6]
        .short_in(short_r), // [RQ2]
        .cmp_in(cmp_in),
        .trial_out(trial_out),
        .busy_out(busy),
        .done_out(done),
        .code_out(code)
    );

    // Busy also covers the start cycle so status rises one cycle after the command
    assign conversion_busy_flag_out = busy | start_r; // [RQ6]
endmodule // abic_ctrl

// *** verification/abic_ain_model.sv ***
// Input level model answering the trial code
`timescale 1ns/1ns
module abic_ain_model (
    input wire [11:0] trial_in, // Trial code
    input wire [11:0] level_in, // Held input level
    output wire cmp_out // High keeps the bit
);
    assign cmp_out = level_in >= trial_in;
endmodule // abic_ain_model

// *** verification/abic_monitor.sv ***
// Port checker for the converter bus interface
`timescale 1ns/1ns
module abic_monitor (
    input wire clk_in, srst_in, select_n_in, chip_en_in, read_conv_in, // Controls
    input wire byte_or_length_select_pin_in, word_mode_in, conversion_busy_flag_out, // Modes
    input wire [11:0] result_output_lines_out, result_output_lines_oe_out // Data lines
);
    wire sel = chip_en_in && !select_n_in;
    wire rd = sel && read_conv_in;
    wire busy = conversion_busy_flag_out;
    wire bls = byte_or_length_select_pin_in;
    wire [11:0] d = result_output_lines_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_start;
        !(sel && !read_conv_in) ##1 (sel && !read_conv_in && !busy);
    endsequence
    a_start_busy: assert property (s_start |=> busy) else $error("start lost");
    a_busy_hold: assert property ($rose(busy) |-> busy[*8]) else $error("busy short");
    a_busy_end: assert property ($rose(busy) |-> ##[1:1000] !busy) else $error("busy hung");
    a_unsel_quiet: assert property (!sel && !busy |=> !busy) else $error("stray start");
    a_read_noconv: assert property (rd && !busy |=> !busy) else $error("read started");
    a_read_drive: assert property (rd |=> result_output_lines_oe_out == 12'hFFF)
        else $error("not driving");
    a_float_off: assert property (!rd |=> result_output_lines_oe_out == 12'h000)
        else $error("not floating");
    a_low_byte: assert property (rd && !word_mode_in && bls |=> d[11:8] == 0 && d[3:0] == 0)
        else $error("low byte form");
    a_high_byte: assert property (rd && !word_mode_in && !bls |=> d[11:8] == 0)
        else $error("high byte form");
endmodule // abic_monitor

// *** verification/test_abic_ctrl.sv ***
// Self-checking bench for the converter bus interface
`timescale 1ns/1ns
module test_abic_ctrl;
    reg clk_in = 0, srst_in = 1, sn = 1, ce = 0, rc = 1, bls = 0, wm = 1;
    reg [11:0] lvl = 12'hA5C;
    wire cmp, busy;
    wire [11:0] trial, dat, oe;
    integer bad_count = 0, checks = 0, n;
    abic_ctrl #(.BIT_CYC(2)) u_abic_ctrl (.clk_in(clk_in), .srst_in(srst_in), .clk_en_in(1'b1),
        .select_n_in(sn), .chip_en_in(ce), .read_conv_in(rc), .byte_or_length_select_pin_in(bls),
        .word_mode_in(wm), .cmp_in(cmp), .trial_out(trial), .conversion_busy_flag_out(busy),
        .result_output_lines_out(dat), .result_output_lines_oe_out(oe));
    abic_ain_model u_abic_ain_model (.trial_in(trial), .level_in(lvl), .cmp_out(cmp));
    initial forever #5 clk_in = ~clk_in;
    task check(input [63:0] what, input [11:0] seen, input [11:0] exp); begin
        checks = checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected %0s: expected %h seen %h", what, exp, seen);
        end
    end endtask
    task drive(input s, input c, input r, input a, input w); begin
        @(posedge clk_in);
        {sn, ce, rc, bls, wm} <= {s, c, r, a, w};
    end endtask
    task convert(input a); begin
        drive(0, 1, 0, a, 1);
        drive(1, 0, 1, 0, 1);
        #1 check("busy", busy, 1);
        // A start while busy must not cut the running conversion short
        drive(0, 1, 0, 1, 1);
        drive(1, 0, 1, 0, 1);
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(posedge clk_in);
            #1 n = n + 1;
        end
        check("done", n < 100, 1);
    end endtask
    task rd(input a, input w, input [11:0] exp); begin
        drive(0, 1, 1, a, w);
        @(posedge clk_in);
        #1 check("oe", oe, 12'hFFF);
        check("data", dat, exp);
        drive(1, 0, 1, a, w);
        @(posedge clk_in);
        #1 check("float", oe, 12'h000);
    end endtask
    task end_of_test; begin
        if (bad_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    end endtask
    initial begin
        #200000 bad_count = bad_count + 1;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge clk_in);
        srst_in <= 0;
        drive(1, 1, 0, 0, 1);
        @(posedge clk_in);
        #1 check("idle", busy, 0);
        drive(0, 0, 0, 0, 1);
        @(posedge clk_in);
        #1 check("idle", busy, 0);
        convert(0);
        rd(0, 1, lvl);
        rd(0, 0, {4'h0, lvl[11:4]});
        rd(1, 0, {4'h0, lvl[3:0], 4'h0});
        lvl <= 12'h3C7;
        convert(1);
        rd(0, 1, {lvl[11:4], 4'h0});
        end_of_test;
    end
endmodule // test_abic_ctrl
bind abic_ctrl abic_monitor u_abic_monitor (.*);
